/* design/card_irq_pm.sv */
// card and management interrupt steering plus chip power-mode control
// assumes card pins are asynchronous; control bits come from same-clock
// register logic; pads resolve each pin from its output and enable

module card_irq_pm
	import irq_pm_pkg::*;
#(
	parameter int NS        = irq_pm_pkg::NUM_SOCKETS,
	parameter int IDLE_CNT  = irq_pm_pkg::IDLE_CYC,
	parameter int PULSE_CNT = irq_pm_pkg::SHARE_PULSE_CYC
) (
	// clock and reset
	input  wire logic                         clock,
	input  wire logic                         rst_b,
	// power/clock control register
	input  wire logic                         pwr_ctl_wr,
	input  wire logic [7:0]                   pwr_ctl_wdata,
	output logic      [7:0]                   pwr_ctl_r,
	// per-socket control bits
	input  wire logic [NS-1:0]                card_pci_route,
	input  wire logic [NS-1:0]                mgmt_pci_route,
	input  wire logic [NS*irq_pm_pkg::CTL_W-1:0] gen_ctl,
	input  wire logic [NS-1:0]                card_is_io,
	// steering
	input  wire logic [NS*irq_pm_pkg::SEL_W-1:0] card_irq_sel,
	input  wire logic [NS*irq_pm_pkg::SEL_W-1:0] mgmt_irq_sel,
	input  wire logic [irq_pm_pkg::NUM_PINS-1:0] pin_od_cfg,
	input  wire logic [irq_pm_pkg::NUM_PINS-1:0] pin_share_cfg,
	// status change enable, clear and flags
	input  wire logic [NS*irq_pm_pkg::CSC_W-1:0] csc_en,
	input  wire logic [NS*irq_pm_pkg::CSC_W-1:0] csc_clr,
	output logic      [NS*irq_pm_pkg::CSC_W-1:0] csc_status_r,
	// card pins
	input  wire logic [2*NS-1:0]              card_detect_n,
	input  wire logic [NS-1:0]                rdy_ireq,
	input  wire logic [NS-1:0]                bvd1_stschg_n,
	input  wire logic [NS-1:0]                bvd2,
	// socket supply control and voltage sense
	input  wire logic [4*NS-1:0]              sock_pwr_ctl,
	output logic      [4*NS-1:0]              sock_pwr_r,
	input  wire logic [2*NS-1:0]              volt_sense,
	output logic      [2*NS-1:0]              volt_status_r,
	// activity
	input  wire logic                         pci_active,
	input  wire logic                         card_bus_busy,
	input  wire logic                         card_access_req,
	input  wire logic                         reg_access,
	// interrupt pins
	output logic      [irq_pm_pkg::NUM_PINS-1:0] irq_pin_o,
	output logic      [irq_pm_pkg::NUM_PINS-1:0] irq_pin_oe,
	input  wire logic                         ext_clk_pin,
	output logic                              ring_indicate_out_n,
	// power state
	output logic                              core_clk_en_r,
	output logic                              core_tick_r,
	output logic                              card_hold_r,
	output logic                              card_access_en_r,
	output pm_state_t                         pm_state_r
);

	import irq_pm_pkg::*;

	localparam int IN_W  = 7 * NS + 1;
	localparam int CNT_W = $clog2(IDLE_CNT + 1);

	logic [IN_W-1:0]           pins_raw;
	logic [IN_W-1:0]           pins_s;
	logic [IN_W-1:0]           pins_d_r;
	logic [1:0]                settle_r;
	logic [2*NS-1:0]           cd_s;
	logic [NS-1:0]             ireq_s;
	logic [NS-1:0]             stschg_s;
	logic [NS-1:0]             bvd2_s;
	logic [NS-1:0]             ireq_d;
	logic [NS-1:0]             stschg_d;
	logic [NS-1:0]             bvd2_d;
	logic [2*NS-1:0]           cd_d;
	logic                      ext_s;
	logic                      ext_d;
	logic [NS*CSC_W-1:0]       csc_set;
	logic [NS-1:0]             inserted;
	logic [NS-1:0]             card_irq;
	logic [NS-1:0]             mgmt_irq;
	logic                      cd_evt;
	logic [NUM_PINS-1:0]       pin_req;
	logic [NUM_PINS-1:0]       pin_routed;
	logic [NUM_PINS-1:0]       pin_od;
	logic                      ring_n_nxt;
	logic                      ext_mode;
	logic                      ring_mode;
	logic                      dyn_en;
	logic                      susp;
	logic                      activity;
	pm_state_t                 pm_nxt;
	logic [CNT_W-1:0]          idle_cnt_r;

	// every card pin crosses two flip-flops first
	assign pins_raw = {ext_clk_pin, volt_sense, bvd2, bvd1_stschg_n,
		rdy_ireq, card_detect_n};

	sync2 #(
		.W (IN_W)
	) u_sync (
		.clock (clock),
		.rst_b (rst_b),
		.d     (pins_raw),
		.q     (pins_s)
	);

	// field slices of synchronised and previous pin levels
	assign cd_s     = pins_s[2*NS-1:0];
	assign ireq_s   = pins_s[3*NS-1:2*NS];
	assign stschg_s = pins_s[4*NS-1:3*NS];
	assign bvd2_s   = pins_s[5*NS-1:4*NS];
	assign ext_s    = pins_s[7*NS];
	assign cd_d     = pins_d_r[2*NS-1:0];
	assign ireq_d   = pins_d_r[3*NS-1:2*NS];
	assign stschg_d = pins_d_r[4*NS-1:3*NS];
	assign bvd2_d   = pins_d_r[5*NS-1:4*NS];
	assign ext_d    = pins_d_r[7*NS];

	// previous levels; events held off until synchronisers settle
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pins_d_r <= '0;
			settle_r <= '0;
		end else begin
			pins_d_r <= pins_s;
			if (settle_r != 2'h3) begin
				settle_r <= settle_r + 2'h1;
			end
		end
	end

	// power/clock control register, writable even in suspend
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pwr_ctl_r <= PCC_RESET;
		end else if (pwr_ctl_wr) begin
			pwr_ctl_r <= pwr_ctl_wdata;
		end
	end

	assign ext_mode  = pwr_ctl_r[PCC_EXT_CLK];
	assign ring_mode = pwr_ctl_r[PCC_RING];
	assign dyn_en    = pwr_ctl_r[PCC_DYN];
	assign susp      = pwr_ctl_r[PCC_SUSPEND];

	// card and status change events per socket
	always_comb begin
		csc_set  = '0;
		inserted = '0;
		card_irq = '0;
		cd_evt   = 1'b0;
		for (int s = 0; s < NS; s++) begin
			inserted[s] = ~cd_s[2*s] & ~cd_s[2*s+1];
			if (settle_r == 2'h3) begin
				csc_set[s*CSC_W+CSC_DETECT] =
					(cd_s[2*s+:2] != cd_d[2*s+:2]);
				csc_set[s*CSC_W+CSC_BVD2] =
					~card_is_io[s] & (bvd2_s[s] ^ bvd2_d[s]);
				csc_set[s*CSC_W+CSC_STSCHG] =
					stschg_s[s] ^ stschg_d[s];
				csc_set[s*CSC_W+CSC_RDY] =
					~card_is_io[s] & (ireq_s[s] ^ ireq_d[s]);
			end
			cd_evt = cd_evt | csc_set[s*CSC_W+CSC_DETECT];
			// io card pulls its request line low
			card_irq[s] = card_is_io[s] & inserted[s] & ~ireq_s[s];
		end
		csc_set = csc_set & csc_en;
	end

	// sticky change flags; a new event beats a clear in the same cycle
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			csc_status_r <= '0;
		end else begin
			csc_status_r <= (csc_status_r & ~csc_clr) | csc_set;
		end
	end

	// any pending flag of a socket raises its management interrupt
	always_comb begin
		for (int s = 0; s < NS; s++) begin
			mgmt_irq[s] = |csc_status_r[s*CSC_W+:CSC_W];
		end
	end

	// steering of both classes to pins; runs ungated, also in suspend
	always_comb begin
		logic [NUM_PINS-1:0] cm;
		logic [NUM_PINS-1:0] mm;
		cm         = '0;
		mm         = '0;
		pin_req    = '0;
		pin_routed = '0;
		pin_od     = pin_od_cfg;
		for (int s = 0; s < NS; s++) begin
			cm = route_mask(card_irq_sel[s*SEL_W+:SEL_W]);
			mm = route_mask(mgmt_irq_sel[s*SEL_W+:SEL_W]);
			pin_routed = pin_routed | cm | mm;
			pin_req = pin_req | (cm & {NUM_PINS{card_irq[s]}})
				| (mm & {NUM_PINS{mgmt_irq[s]}});
			if (card_pci_route[s]) begin
				pin_od = pin_od | cm;
			end
			if (mgmt_pci_route[s]) begin
				pin_od = pin_od | mm;
			end
		end
	end

	// ring level: status change of accepting io sockets, active low
	always_comb begin
		ring_n_nxt = 1'b1;
		for (int s = 0; s < NS; s++) begin
			if (card_is_io[s] && gen_ctl[s*CTL_W+GEN_RI_A]
				&& gen_ctl[s*CTL_W+GEN_RI_B]) begin
				ring_n_nxt = ring_n_nxt & stschg_s[s];
			end
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			ring_indicate_out_n <= 1'b1;
		end else begin
			ring_indicate_out_n <= ~ring_mode | ring_n_nxt;
		end
	end

	// one driver per pin; the dual pins switch function on control bits
	for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
		irq_pin_drv #(
			.PULSE_CYC (PULSE_CNT)
		) u_drv (
			.clock      (clock),
			.rst_b      (rst_b),
			.req        (pin_req[i]),
			.routed     (pin_routed[i]),
			.open_drain (pin_od[i]),
			.share      (pin_share_cfg[i]),
			.force_off  ((i == PIN_EXT_CLK) && ext_mode),
			.force_on   ((i == PIN_RING) && ring_mode),
			.force_val  (ring_n_nxt),
			.pin_o      (irq_pin_o[i]),
			.pin_oe     (irq_pin_oe[i])
		);
	end

	// anything that must wake the core
	assign activity = card_bus_busy | card_access_req | reg_access
		| cd_evt;

	// power mode transitions
	always_comb begin
		pm_nxt = pm_state_r;
		case (pm_state_r)
			PM_RUN: begin
				if (susp) begin
					pm_nxt = PM_SUSPEND;
				end else if (dyn_en && !activity
					&& idle_cnt_r == CNT_W'(IDLE_CNT - 1)) begin
					pm_nxt = PM_IDLE;
				end
			end
			PM_IDLE: begin
				if (susp) begin
					pm_nxt = PM_SUSPEND;
				end else if (!dyn_en || activity) begin
					pm_nxt = PM_RUN;
				end
			end
			PM_SUSPEND: begin
				if (!susp) begin
					pm_nxt = PM_RUN;
				end
			end
			default: begin
				pm_nxt = PM_RUN;
			end
		endcase
	end

	// state and quiet-time counter; idle entry needs a full quiet time
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pm_state_r <= PM_RUN;
			idle_cnt_r <= '0;
		end else begin
			pm_state_r <= pm_nxt;
			if (pm_state_r != PM_RUN || activity || !dyn_en) begin
				idle_cnt_r <= '0;
			end else if (idle_cnt_r != CNT_W'(IDLE_CNT - 1)) begin
				idle_cnt_r <= idle_cnt_r + 1'b1;
			end
		end
	end

	// clock gating and card bus controls; nothing here stalls the host
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			core_clk_en_r    <= 1'b1;
			core_tick_r      <= 1'b1;
			card_hold_r      <= 1'b0;
			card_access_en_r <= 1'b1;
		end else begin
			core_clk_en_r    <= (pm_nxt == PM_RUN);
			// external clock edges pace the core while the host bus rests
			core_tick_r      <= (pm_nxt == PM_RUN)
				&& (pci_active || !ext_mode
				|| (ext_s && !ext_d));
			card_hold_r      <= (pm_nxt != PM_RUN);
			card_access_en_r <= (pm_nxt != PM_SUSPEND);
		end
	end

	// supply control passes through untouched by any power mode
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			sock_pwr_r    <= '0;
			volt_status_r <= '0;
		end else begin
			sock_pwr_r    <= sock_pwr_ctl;
			volt_status_r <= pins_s[7*NS-1:5*NS];
		end
	end

endmodule : card_irq_pm

/* design/irq_pm_pkg.sv */
// shared constants and types for card interrupt steering and power modes
// assumes one 200 MHz clock; no register bus, control bits arrive as ports
package irq_pm_pkg;

	// pin and socket counts
	localparam int NUM_PINS    = 10;
	localparam int NUM_SOCKETS = 2;
	localparam int SEL_W       = 4;
	localparam int CSC_W       = 4;
	localparam int CTL_W       = 8;

	// dual-function pins (interrupt 14 and 15)
	localparam int PIN_EXT_CLK = 8;
	localparam int PIN_RING    = 9;

	// power/clock control register fields and reset value
	localparam int          PCC_EXT_CLK = 0;
	localparam int          PCC_DYN     = 1;
	localparam int          PCC_SUSPEND = 2;
	localparam int          PCC_RING    = 7;
	localparam logic [7:0]  PCC_RESET   = 8'h02;

	// general control bits that both gate ring indicate
	localparam int GEN_RI_A = 5;
	localparam int GEN_RI_B = 7;

	// status change source positions in each socket field
	localparam int CSC_DETECT = 0;
	localparam int CSC_BVD2   = 1;
	localparam int CSC_STSCHG = 2;
	localparam int CSC_RDY    = 3;

	// timing: least times, rounded up to whole cycles
	localparam int CLK_MHZ         = 200;
	localparam int IDLE_NS         = 1000;
	localparam int IDLE_CYC        = (IDLE_NS * CLK_MHZ + 999) / 1000;
	localparam int SHARE_PULSE_NS  = 100;
	localparam int SHARE_PULSE_CYC =
		(SHARE_PULSE_NS * CLK_MHZ + 999) / 1000;

	// power mode states
	typedef enum logic [1:0] {
		PM_RUN     = 2'b00,
		PM_IDLE    = 2'b01,
		PM_SUSPEND = 2'b10
	} pm_state_t;

	// selectors 0 and 11 to 15 route nowhere, k from 1 to 10 routes to pin k-1
	function automatic logic [NUM_PINS-1:0] route_mask(
		input logic [SEL_W-1:0] sel);
		logic [NUM_PINS-1:0] m;
		m = '0;
		for (int i = 0; i < NUM_PINS; i++) begin
			if (sel == SEL_W'(i + 1)) begin
				m[i] = 1'b1;
			end
		end
		return m;
	endfunction : route_mask

endpackage : irq_pm_pkg

/* design/sync2.sv */
// two-stage synchroniser for a vector of pin inputs
// assumes each bit is an independent level from outside the clock domain
module sync2 #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clock,
	input  wire logic         rst_b,
	// raw and synchronised levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_r;

	// first stage feeds only the second
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end

endmodule : sync2

/* design/irq_pin_drv.sv */
// one interrupt pin driver: open-drain, totem-pole or pulse-and-release
// assumes the pad resolves level from pin_o and pin_oe
module irq_pin_drv
	import irq_pm_pkg::*;
#(
	parameter int PULSE_CYC = irq_pm_pkg::SHARE_PULSE_CYC
) (
	// clock and reset
	input  wire logic clock,
	input  wire logic rst_b,
	// request and configuration
	input  wire logic req,
	input  wire logic routed,
	input  wire logic open_drain,
	input  wire logic share,
	// alternate pin functions
	input  wire logic force_off,
	input  wire logic force_on,
	input  wire logic force_val,
	// pad
	output logic      pin_o,
	output logic      pin_oe
);

	localparam int CW = $clog2(PULSE_CYC + 1);

	logic          req_d_r;
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;
	logic          rise;

	assign rise = req & ~req_d_r;

	// pulse length counter, started by a rising request
	always_comb begin
		cnt_nxt = cnt_r;
		if (rise && share && !open_drain) begin
			cnt_nxt = CW'(PULSE_CYC);
		end else if (cnt_r != '0) begin
			cnt_nxt = cnt_r - 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			req_d_r <= 1'b0;
			cnt_r   <= '0;
		end else begin
			req_d_r <= req;
			cnt_r   <= cnt_nxt;
		end
	end

	// pad drive per mode
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pin_o  <= 1'b0;
			pin_oe <= 1'b0;
		end else if (force_off) begin
			pin_o  <= 1'b0;
			pin_oe <= 1'b0;
		end else if (force_on) begin
			pin_o  <= force_val;
			pin_oe <= 1'b1;
		end else if (!routed) begin
			pin_o  <= 1'b0;
			pin_oe <= ~open_drain;
		end else if (open_drain) begin
			pin_o  <= 1'b0;
			pin_oe <= req;
		end else if (share) begin
			pin_o  <= 1'b1;
			pin_oe <= (cnt_nxt != '0);
		end else begin
			pin_o  <= req;
			pin_oe <= 1'b1;
		end
	end

endmodule : irq_pin_drv

/* testbench/irq_line_model.sv */
// host side of the ten interrupt lines, each with a pull-up
// assumes the block's pad output and enable for every line
module irq_line_model
	import irq_pm_pkg::*;
(
	// pad side of the block
	input  wire logic [irq_pm_pkg::NUM_PINS-1:0] pin_o,
	input  wire logic [irq_pm_pkg::NUM_PINS-1:0] pin_oe,
	// level seen by the host interrupt inputs
	output logic      [irq_pm_pkg::NUM_PINS-1:0] pin_level
);
	timeunit 1ns;
	timeprecision 1ps;
	// a released line floats up to the pull-up level
	always_comb begin
		for (int i = 0; i < NUM_PINS; i++) begin
			pin_level[i] = pin_oe[i] ? pin_o[i] : 1'b1;
		end
	end
endmodule : irq_line_model

/* testbench/card_irq_pm_properties.sv */
// timing checks on power modes and alternate pin functions
// assumes binding into card_irq_pm and watching only its ports
module card_irq_pm_checker
	import irq_pm_pkg::*;
#(
	parameter int IDLE_CNT = 4
) (
	// clock and reset
	input wire logic                             clock,
	input wire logic                             rst_b,
	// control and activity
	input wire logic                             pwr_ctl_wr,
	input wire logic [7:0]                       pwr_ctl_wdata,
	input wire logic [7:0]                       pwr_ctl_r,
	input wire logic                             reg_access,
	input wire logic                             card_bus_busy,
	input wire logic                             card_access_req,
	// outputs watched
	input wire logic [irq_pm_pkg::NUM_PINS-1:0]  irq_pin_oe,
	input wire logic                             ring_indicate_out_n,
	input wire logic                             core_clk_en_r,
	input wire logic                             card_hold_r,
	input wire logic                             card_access_en_r,
	input wire irq_pm_pkg::pm_state_t            pm_state_r
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] quiet_r;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);
	// consecutive cycles without any access, saturating
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			quiet_r <= '0;
		end else if (reg_access || card_bus_busy || card_access_req) begin
			quiet_r <= '0;
		end else if (quiet_r != 16'hffff) begin
			quiet_r <= quiet_r + 16'h1;
		end
	end
	property p_wr_load;
		pwr_ctl_wr |=> pwr_ctl_r == $past(pwr_ctl_wdata);
	endproperty
	a_wr_load: assert property (p_wr_load)
		else $error("power control write not loaded");
	property p_susp_in;
		pwr_ctl_r[PCC_SUSPEND] |=> pm_state_r == PM_SUSPEND;
	endproperty
	a_susp_in: assert property (p_susp_in)
		else $error("suspend not entered");
	property p_susp_out;
		pm_state_r == PM_SUSPEND && !pwr_ctl_r[PCC_SUSPEND]
			|=> pm_state_r == PM_RUN;
	endproperty
	a_susp_out: assert property (p_susp_out)
		else $error("suspend not left");
	property p_susp_gate;
		pm_state_r == PM_SUSPEND |-> !card_access_en_r && !core_clk_en_r;
	endproperty
	a_susp_gate: assert property (p_susp_gate)
		else $error("card access or clock open in suspend");
	property p_normal;
		!pwr_ctl_r[PCC_DYN] && !pwr_ctl_r[PCC_SUSPEND] |=> pm_state_r == PM_RUN;
	endproperty
	a_normal: assert property (p_normal)
		else $error("low power state in normal mode");
	property p_idle_hold;
		pm_state_r == PM_IDLE |-> card_hold_r && !core_clk_en_r;
	endproperty
	a_idle_hold: assert property (p_idle_hold)
		else $error("idle state without clock stop and hold");
	property p_wake;
		pm_state_r == PM_IDLE && reg_access && !pwr_ctl_r[PCC_SUSPEND]
			|=> pm_state_r == PM_RUN;
	endproperty
	a_wake: assert property (p_wake)
		else $error("register access did not wake");
	property p_idle_late;
		$rose(pm_state_r == PM_IDLE) |-> quiet_r >= IDLE_CNT - 1;
	endproperty
	a_idle_late: assert property (p_idle_late)
		else $error("idle entered too early");
	property p_ring_off;
		!pwr_ctl_r[PCC_RING] |=> ring_indicate_out_n;
	endproperty
	a_ring_off: assert property (p_ring_off)
		else $error("ring output active with ring mode off");
	property p_ext_float;
		pwr_ctl_r[PCC_EXT_CLK] [*2] |-> !irq_pin_oe[PIN_EXT_CLK];
	endproperty
	a_ext_float: assert property (p_ext_float)
		else $error("external clock pin still driven");
	// main scenarios reached
	c_susp: cover property (pm_state_r == PM_SUSPEND);
	c_idle: cover property (pm_state_r == PM_IDLE);
	c_ring: cover property (!ring_indicate_out_n);
endmodule : card_irq_pm_checker

bind card_irq_pm card_irq_pm_checker #(
	.IDLE_CNT(IDLE_CNT)
) u_chk (
	.clock(clock), .rst_b(rst_b), .pwr_ctl_wr(pwr_ctl_wr),
	.pwr_ctl_wdata(pwr_ctl_wdata), .pwr_ctl_r(pwr_ctl_r),
	.reg_access(reg_access), .card_bus_busy(card_bus_busy),
	.card_access_req(card_access_req), .irq_pin_oe(irq_pin_oe),
	.ring_indicate_out_n(ring_indicate_out_n),
	.core_clk_en_r(core_clk_en_r), .card_hold_r(card_hold_r),
	.card_access_en_r(card_access_en_r), .pm_state_r(pm_state_r)
);

/* testbench/card_irq_steering_power_modes_tb_top.sv */
// self-checking bench for card interrupt steering and power modes
// assumes the pull-up line model and short idle and pulse counts
module card_irq_steering_power_modes_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import irq_pm_pkg::*;
	localparam int         IDLE   = 4;
	localparam int         PULSE  = 3;
	localparam logic [9:0] OD_MAP = 10'h155;
	typedef struct packed { logic [3:0] sel; logic [9:0] lvl; } row_t;
	// dut inputs
	logic        clock, rst_b, pwr_ctl_wr, pci_active, card_bus_busy;
	logic        card_access_req, reg_access, ext_clk_pin;
	logic [1:0]  card_pci_route, mgmt_pci_route, card_is_io, rdy_ireq;
	logic [1:0]  bvd1_stschg_n, bvd2;
	logic [3:0]  card_detect_n, volt_sense;
	logic [7:0]  pwr_ctl_wdata, card_irq_sel, mgmt_irq_sel, csc_en, csc_clr;
	logic [7:0]  sock_pwr_ctl;
	logic [9:0]  pin_od_cfg, pin_share_cfg;
	logic [15:0] gen_ctl;
	// dut outputs and line levels
	logic [7:0]  pwr_ctl_r, csc_status_r, sock_pwr_r;
	logic [3:0]  volt_status_r;
	logic [9:0]  irq_pin_o, irq_pin_oe, pin_level;
	logic        ring_indicate_out_n, core_clk_en_r, card_hold_r;
	logic        card_access_en_r, core_tick_r;
	pm_state_t   pm_state_r;
	int          err_total = 0;
	int          checks_done = 0;
	int          n;
	// card interrupt selector beside expected line levels
	row_t rows [10] = '{'{4'h1, 10'h154}, '{4'h2, 10'h157},
		'{4'h3, 10'h151}, '{4'h4, 10'h15d}, '{4'h5, 10'h145},
		'{4'h6, 10'h175}, '{4'h7, 10'h115}, '{4'h8, 10'h1d5},
		'{4'h9, 10'h055}, '{4'ha, 10'h355}};

	card_irq_pm #(.IDLE_CNT(IDLE), .PULSE_CNT(PULSE)) dut (
		.clock(clock), .rst_b(rst_b), .pwr_ctl_wr(pwr_ctl_wr),
		.pwr_ctl_wdata(pwr_ctl_wdata), .pwr_ctl_r(pwr_ctl_r),
		.card_pci_route(card_pci_route), .mgmt_pci_route(mgmt_pci_route),
		.gen_ctl(gen_ctl), .card_is_io(card_is_io),
		.card_irq_sel(card_irq_sel), .mgmt_irq_sel(mgmt_irq_sel),
		.pin_od_cfg(pin_od_cfg), .pin_share_cfg(pin_share_cfg),
		.csc_en(csc_en), .csc_clr(csc_clr), .csc_status_r(csc_status_r),
		.card_detect_n(card_detect_n), .rdy_ireq(rdy_ireq),
		.bvd1_stschg_n(bvd1_stschg_n), .bvd2(bvd2),
		.sock_pwr_ctl(sock_pwr_ctl), .sock_pwr_r(sock_pwr_r),
		.volt_sense(volt_sense), .volt_status_r(volt_status_r),
		.pci_active(pci_active), .card_bus_busy(card_bus_busy),
		.card_access_req(card_access_req), .reg_access(reg_access),
		.irq_pin_o(irq_pin_o), .irq_pin_oe(irq_pin_oe),
		.ext_clk_pin(ext_clk_pin),
		.ring_indicate_out_n(ring_indicate_out_n),
		.core_clk_en_r(core_clk_en_r), .core_tick_r(core_tick_r),
		.card_hold_r(card_hold_r), .card_access_en_r(card_access_en_r),
		.pm_state_r(pm_state_r));
	irq_line_model host (
		.pin_o(irq_pin_o), .pin_oe(irq_pin_oe), .pin_level(pin_level));

	// 200 MHz clock and an unrelated slow external clock
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	initial begin
		ext_clk_pin = 1'b0;
		forever #7 ext_clk_pin = ~ext_clk_pin;
	end
	// watchdog against a hang
	initial begin
		repeat (20000) @(posedge clock);
		err_total++;
		close_out();
	end

	task automatic tick(input int k);
		repeat (k) @(posedge clock);
	endtask : tick
	task automatic look(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : look
	// one write, ending where the power state has followed it
	task automatic pwr_write(input logic [7:0] v);
		tick(1);
		pwr_ctl_wr    <= 1'b1;
		pwr_ctl_wdata <= v;
		tick(1);
		pwr_ctl_wr <= 1'b0;
		tick(1);
		@(negedge clock);
	endtask : pwr_write
	task automatic close_out();
		if (err_total == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : close_out

	initial begin
		// socket 0 an I/O card, socket 1 a memory card, both present
		{rst_b, pwr_ctl_wr, pci_active, card_bus_busy} = '0;
		{card_access_req, reg_access, pwr_ctl_wdata, gen_ctl} = '0;
		{card_pci_route, mgmt_pci_route, card_irq_sel, csc_en} = '0;
		{csc_clr, card_detect_n, pin_share_cfg, bvd2} = '0;
		{card_is_io, rdy_ireq, bvd1_stschg_n} = 6'b01_11_11;
		{mgmt_irq_sel, sock_pwr_ctl, volt_sense} = 20'h405a9;
		pin_od_cfg = OD_MAP;
		tick(4);
		@(negedge clock);
		look("pwr_ctl_r", 16'h02, 16'(pwr_ctl_r));
		look("ring_n", 16'h1, 16'(ring_indicate_out_n));
		tick(1);
		rst_b <= 1'b1;
		tick(IDLE + 8);
		@(negedge clock);
		look("sleep", 16'(PM_IDLE), 16'(pm_state_r));
		look("card_hold", 16'h1, 16'(card_hold_r));
		look("sock_pwr", 16'h5a, 16'(sock_pwr_r));
		look("volt", 16'h9, 16'(volt_status_r));
		tick(1);
		reg_access <= 1'b1;
		tick(1);
		reg_access <= 1'b0;
		@(negedge clock);
		look("wake", 16'(PM_RUN), 16'(pm_state_r));
		tick(IDLE + 4);
		@(negedge clock);
		look("resleep", 16'(PM_IDLE), 16'(pm_state_r));
		// card interrupt steered to each pin in turn
		foreach (rows[k]) begin
			tick(1);
			card_irq_sel[3:0] <= rows[k].sel;
			card_pci_route[0] <= OD_MAP[k];
			rdy_ireq[0]       <= 1'b0;
			tick(5);
			@(negedge clock);
			look("card line", 16'(rows[k].lvl), 16'(pin_level));
			tick(1);
			rdy_ireq[0] <= 1'b1;
			tick(5);
			@(negedge clock);
			look("idle line", 16'(OD_MAP), 16'(pin_level));
		end
		// every status source changes, only the enabled one counts
		for (int j = 0; j < 4; j++) begin
			tick(1);
			csc_en[7:4] <= 4'(1 << j);
			tick(1);
			card_detect_n[2] <= ~card_detect_n[2];
			bvd2[1]          <= ~bvd2[1];
			bvd1_stschg_n[1] <= ~bvd1_stschg_n[1];
			rdy_ireq[1]      <= ~rdy_ireq[1];
			tick(6);
			@(negedge clock);
			look("csc", 16'({4'(1 << j), 4'h0}), 16'(csc_status_r));
			look("mgmt line", 16'h15d, 16'(pin_level));
			tick(1);
			csc_clr[4 + j] <= 1'b1;
			tick(1);
			csc_clr <= 8'h00;
			tick(3);
			@(negedge clock);
			look("mgmt cleared", 16'(OD_MAP), 16'(pin_level));
		end
		// pulse-and-release sharing on totem pin 5
		tick(1);
		pin_share_cfg[5]  <= 1'b1;
		card_irq_sel[3:0] <= 4'h6;
		card_pci_route[0] <= 1'b0;
		tick(2);
		rdy_ireq[0] <= 1'b0;
		for (int w = 0; w < 20 && irq_pin_oe[5] !== 1'b1; w++) begin
			@(negedge clock);
		end
		n = 0;
		while (irq_pin_o[5] === 1'b1 && irq_pin_oe[5] === 1'b1 && n < 20) begin
			n++;
			@(negedge clock);
		end
		look("pulse length", 16'(PULSE), 16'(n));
		tick(4);
		@(negedge clock);
		look("pulse released", 16'h0, 16'(irq_pin_oe[5]));
		tick(1);
		rdy_ireq[0]      <= 1'b1;
		pin_share_cfg[5] <= 1'b0;
		sock_pwr_ctl     <= 8'h00;
		pwr_write(8'h00);
		tick(IDLE + 4);
		@(negedge clock);
		look("normal", 16'(PM_RUN), 16'(pm_state_r));
		look("tick run", 16'h1, 16'(core_tick_r));
		pwr_write(8'h04);
		look("suspend", 16'(PM_SUSPEND), 16'(pm_state_r));
		look("pwr reg", 16'h04, 16'(pwr_ctl_r));
		look("card access", 16'h0, 16'(card_access_en_r));
		tick(1);
		reg_access        <= 1'b1;
		card_access_req   <= 1'b1;
		card_irq_sel[3:0] <= 4'h1;
		rdy_ireq[0]       <= 1'b0;
		tick(6);
		reg_access      <= 1'b0;
		card_access_req <= 1'b0;
		@(negedge clock);
		look("held", 16'(PM_SUSPEND), 16'(pm_state_r));
		look("suspend line", 16'h154, 16'(pin_level));
		look("supply held", 16'h00, 16'(sock_pwr_r));
		tick(1);
		rdy_ireq[0] <= 1'b1;
		pwr_write(8'h00);
		look("resume", 16'(PM_RUN), 16'(pm_state_r));
		// ring pass-through needs both general control bits
		tick(1);
		gen_ctl[7:0]     <= 8'h20;
		bvd1_stschg_n[0] <= 1'b0;
		pwr_write(8'h80);
		tick(4);
		@(negedge clock);
		look("ring gated", 16'h1, 16'(ring_indicate_out_n));
		tick(1);
		gen_ctl[7:0] <= 8'ha0;
		tick(5);
		@(negedge clock);
		look("ring", 16'h0, 16'(ring_indicate_out_n));
		look("ring line", 16'h0, 16'(pin_level[9]));
		tick(1);
		bvd1_stschg_n[0] <= 1'b1;
		tick(5);
		@(negedge clock);
		look("ring idle", 16'h1, 16'(ring_indicate_out_n));
		pwr_write(8'h01);
		tick(2);
		@(negedge clock);
		look("ext clk pin", 16'h0, 16'(irq_pin_oe[8]));
		// host bus resting: core paced by external clock edges only
		n = 0;
		repeat (28) begin
			@(negedge clock);
			n += int'(core_tick_r);
		end
		look("ext ticks", 16'h1, 16'(n >= 9 && n <= 11));
		tick(1);
		pci_active <= 1'b1;
		tick(2);
		@(negedge clock);
		look("bus ticks", 16'h1, 16'(core_tick_r));
		close_out();
	end
endmodule : card_irq_steering_power_modes_tb_top
